/* File: bsq_pkg.sv */
// Shared constants and types of the external bus write and locked-cycle sequencer
package bsq_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_PERIOD_NS = 20;
	localparam int BUS_CLK_PERIOD_NS = 40;
	// System clocks per bus state (one half of the bus clock), at least one
	localparam int STATE_CYC_RAW = (BUS_CLK_PERIOD_NS / 2) / SYS_CLK_PERIOD_NS;
	localparam int STATE_CYC = (STATE_CYC_RAW < 1) ? 1 : STATE_CYC_RAW;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int FC_W = 3;
	localparam int SIZ_W = 2;
	localparam int REDUCED_ADDR_W = 24;
	localparam int FIFO_DEPTH = 8;
	localparam logic [FC_W-1:0] FC_RESET = 3'h0;
	localparam logic [SIZ_W-1:0] SIZ_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Commands and states
	// ----------------------------------------------------------------
	// Bus cycle kinds queued by the core
	typedef enum logic [1:0] {
		CYC_WRITE,
		CYC_RMC_READ,
		CYC_RMC_WRITE,
		CYC_RMC_END
	} bsq_cyc_t;

	// Operation that issued the cycle
	typedef enum logic [1:0] {
		OP_PLAIN,
		OP_TEST_AND_SET,
		OP_COMPARE_AND_SWAP,
		OP_COMPARE_AND_SWAP_DUAL
	} bsq_op_t;

	typedef struct packed {
		bsq_cyc_t                cyc;
		bsq_op_t                 op;
		logic                    first;
		logic [FC_W-1:0]         fc;
		logic [SIZ_W-1:0]        siz;
		logic [ADDR_W-1:0]       addr;
		logic [DATA_W-1:0]       data;
	} bsq_entry_t;

	localparam int ENTRY_W = $bits(bsq_entry_t);

	typedef enum {
		ST_IDLE,
		ST_S0,
		ST_S1,
		ST_S2,
		ST_SW,
		ST_SWH,
		ST_S3,
		ST_S4,
		ST_S5
	} bsq_state_t;

endpackage : bsq_pkg

/* File: bsq_fifo_if.sv */
// Carrier between the command queue and the bus sequencer
`timescale 1ns/100ps
interface bsq_fifo_if #(
	parameter int WIDTH = 8
);
	logic             wr_valid;
	logic             wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic             rd_valid;
	logic             rd_ready;
	logic [WIDTH-1:0] rd_data;

	modport fifo (
		input  wr_valid,
		output wr_ready,
		input  wr_data,
		output rd_valid,
		input  rd_ready,
		output rd_data
	);

	modport user (
		output wr_valid,
		input  wr_ready,
		output wr_data,
		input  rd_valid,
		output rd_ready,
		input  rd_data
	);
endinterface : bsq_fifo_if

/* File: bsq_fifo.sv */
// Command queue with valid and ready on both sides
`timescale 1ns/100ps
module bsq_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic   i_sys_clk,  // System clock
	input  wire logic   i_reset_n,  // Asynchronous reset, active low
	bsq_fifo_if.fifo    q           // Queue ports
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic             not_full_reg;
	logic             push;
	logic             pop;

	assign push = q.wr_valid && not_full_reg;
	assign pop = q.rd_valid && q.rd_ready;
	assign q.wr_ready = not_full_reg;
	assign q.rd_valid = (count_reg != '0);
	assign q.rd_data = mem[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= q.wr_data;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			not_full_reg <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_next;
			// Registered so the ready port comes from a flop
			not_full_reg <= (count_next != CNT_FULL);
		end
	end

endmodule : bsq_fifo

/* File: bsq_bus_seq.sv */
// Bus master sequencer: write cycles and locked read-modify-write sequences
`timescale 1ns/100ps
// How it works
// - S0 write: address, space, size, write
// - Operand start only on first write cycle
// - Write S1: address strobe and buffer enable
// - Cycle start strobes negated in S1
// - Drive data in S2, sample acknowledges
// - Write S3 asserts data strobe
// - Acknowledge by S2 end: no wait
// - No acknowledge: wait, sample every fall
// - S4 changes no control output
// - S5 drops strobes, holds the rest
// - Reduced variant: 24 address bits, fewer outputs
// - Lock marker held whole locked sequence
// - No bus grant during locked sequence
// - Locked cycles only for three operations
// - Locked S0: both starts, marker, read
// - Locked read S1: both strobes together
// - Locked read asserts buffer enable in S2
// - Idle between portions, no new controls
// - Latch read data, drop all in S5
module bsq_bus_seq #(
	parameter int REDUCED   = 0,                    // 1: reduced variant
	parameter int STATE_CYC = bsq_pkg::STATE_CYC,   // Clocks per bus state
	parameter int DEPTH     = bsq_pkg::FIFO_DEPTH   // Command queue depth
) (
	input  wire logic                  i_sys_clk,        // 50 MHz clock
	input  wire logic                  i_reset_n,        // Async reset
	input  wire logic                  i_cmd_valid,      // Command offered
	output logic                       o_cmd_ready,      // Queue has room
	input  wire logic [1:0]            i_cmd_cyc,        // Cycle kind
	input  wire logic [1:0]            i_cmd_op,         // Issuing operation
	input  wire logic                  i_cmd_first,      // First operand cycle
	input  wire logic [2:0]            i_cmd_fc,         // Address space
	input  wire logic [1:0]            i_cmd_siz,        // Transfer size
	input  wire logic [31:0]           i_cmd_addr,       // Byte address
	input  wire logic [31:0]           i_cmd_data,       // Write data
	output logic                       o_cmd_reject,     // Command dropped
	output logic [31:0]                o_rd_data,        // Locked read data
	output logic                       o_rd_valid,       // Read data pulse
	output logic                       o_bus_clk,        // Bus clock out
	output logic [31:0]                o_address,        // Address lines
	output logic [2:0]                 o_address_space_code, // Space
	output logic                       o_transfer_size_hi,   // Size bit 1
	output logic                       o_transfer_size_lo,   // Size bit 0
	output logic                       o_read_write,     // 1 read, 0 write
	output logic                       o_external_cycle_start_n, // Start
	output logic                       o_operand_cycle_start_n,  // Op start
	output logic                       o_address_strobe_n,   // Address valid
	output logic                       o_data_strobe_n,      // Data valid
	output logic                       o_data_buffer_enable_n, // Buffers
	output logic                       o_indivisible_cycle_marker_n, // Lock
	output logic [31:0]                o_data,           // Data bus out
	output logic                       o_data_oe_n,      // Low: driving
	input  wire logic [31:0]           i_data,           // Data bus in
	input  wire logic                  i_transfer_ack_hi_n, // Ack line 1
	input  wire logic                  i_transfer_ack_lo_n, // Ack line 0
	input  wire logic                  i_bus_request_n,  // Bus request
	output logic                       o_bus_grant_n     // Bus grant
);
	localparam logic RED = (REDUCED != 0);
	localparam int TICK_W = $clog2(STATE_CYC + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STATE_CYC - 1);
	localparam logic [31:0] ADDR_MASK = RED ? 32'h00FFFFFF : 32'hFFFFFFFF;

	// ----------------------------------------------------------------
	// Queue and synchronisers
	// ----------------------------------------------------------------
	bsq_fifo_if #(.WIDTH(bsq_pkg::ENTRY_W)) q ();
	bsq_pkg::bsq_entry_t wr_ent;
	bsq_pkg::bsq_entry_t ent;
	bsq_pkg::bsq_entry_t head;
	bsq_pkg::bsq_entry_t cur_reg;
	bsq_pkg::bsq_state_t state_reg;
	bsq_pkg::bsq_state_t state_next;

	assign wr_ent = '{cyc: bsq_pkg::bsq_cyc_t'(i_cmd_cyc),
		op: bsq_pkg::bsq_op_t'(i_cmd_op), first: i_cmd_first,
		fc: i_cmd_fc, siz: i_cmd_siz, addr: i_cmd_addr, data: i_cmd_data};
	assign q.wr_valid = i_cmd_valid;
	assign q.wr_data = wr_ent;
	assign o_cmd_ready = q.wr_ready;

	bsq_fifo #(.WIDTH(bsq_pkg::ENTRY_W), .DEPTH(DEPTH)) u_fifo (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.q         (q.fifo)
	);

	logic [1:0]  ack_s1_reg;
	logic [1:0]  ack_s2_reg;
	logic        breq_s1_reg;
	logic        breq_s2_reg;
	logic [31:0] din_s1_reg;
	logic [31:0] din_s2_reg;
	logic        ack_any;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ack_s1_reg <= 2'h3;
			ack_s2_reg <= 2'h3;
			breq_s1_reg <= 1'b1;
			breq_s2_reg <= 1'b1;
			din_s1_reg <= 32'h00000000;
			din_s2_reg <= 32'h00000000;
		end else begin
			ack_s1_reg <= {i_transfer_ack_hi_n, i_transfer_ack_lo_n};
			ack_s2_reg <= ack_s1_reg;
			breq_s1_reg <= i_bus_request_n;
			breq_s2_reg <= breq_s1_reg;
			din_s1_reg <= i_data;
			din_s2_reg <= din_s1_reg;
		end
	end

	// Either line low is enough to end the cycle
	assign ack_any = (ack_s2_reg != 2'h3);

	// ----------------------------------------------------------------
	// Bus state timing
	// ----------------------------------------------------------------
	logic [TICK_W-1:0] tick_cnt_reg;
	logic              tick;

	assign tick = (tick_cnt_reg == TICK_LAST);

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tick_cnt_reg <= '0;
			o_bus_clk <= 1'b0;
		end else begin
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
			if (tick) begin
				o_bus_clk <= !o_bus_clk;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic locked;
	logic granted;
	logic bad_cmd;
	logic is_wr;
	logic start;

	assign locked = !o_indivisible_cycle_marker_n;
	assign granted = !o_bus_grant_n;
	// The queue carries a plain vector; view its head as fields
	assign head = q.rd_data;
	assign ent = (state_reg == bsq_pkg::ST_IDLE) ? head : cur_reg;
	assign is_wr = (ent.cyc != bsq_pkg::CYC_RMC_READ);
	// Locked reads need one of the three atomic operations
	assign bad_cmd = (head.cyc == bsq_pkg::CYC_RMC_READ)
		? (head.op == bsq_pkg::OP_PLAIN || locked)
		: ((head.cyc != bsq_pkg::CYC_WRITE) && !locked);
	// S0 opens on a rising bus clock edge, and only from idle, so a
	// queued locked read cannot raise the marker during another cycle
	assign start = (state_reg == bsq_pkg::ST_IDLE) && tick && !o_bus_clk
		&& q.rd_valid && !granted;

	always_comb begin
		state_next = state_reg;
		q.rd_ready = 1'b0;
		case (state_reg)
			bsq_pkg::ST_IDLE: begin
				if (tick && q.rd_valid && !granted
					&& (bad_cmd || head.cyc == bsq_pkg::CYC_RMC_END)) begin
					q.rd_ready = 1'b1;
				end else if (start) begin
					q.rd_ready = 1'b1;
					state_next = bsq_pkg::ST_S0;
				end
			end
			bsq_pkg::ST_S0: if (tick) state_next = bsq_pkg::ST_S1;
			bsq_pkg::ST_S1: if (tick) state_next = bsq_pkg::ST_S2;
			bsq_pkg::ST_S2: begin
				if (tick) begin
					state_next = ack_any ? bsq_pkg::ST_S3 : bsq_pkg::ST_SW;
				end
			end
			bsq_pkg::ST_SW: if (tick) state_next = bsq_pkg::ST_SWH;
			bsq_pkg::ST_SWH: begin
				if (tick) begin
					state_next = ack_any ? bsq_pkg::ST_S3 : bsq_pkg::ST_SW;
				end
			end
			bsq_pkg::ST_S3: if (tick) state_next = bsq_pkg::ST_S4;
			bsq_pkg::ST_S4: if (tick) state_next = bsq_pkg::ST_S5;
			bsq_pkg::ST_S5: if (tick) state_next = bsq_pkg::ST_IDLE;
			default: state_next = bsq_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= bsq_pkg::ST_IDLE;
			cur_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (q.rd_ready) begin
				cur_reg <= q.rd_data;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cmd_reject <= 1'b0;
		end else begin
			o_cmd_reject <= q.rd_ready && bad_cmd;
		end
	end

	// ----------------------------------------------------------------
	// Bus outputs, updated as each state is entered
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_address <= 32'h00000000;
			o_address_space_code <= bsq_pkg::FC_RESET;
			{o_transfer_size_hi, o_transfer_size_lo} <= bsq_pkg::SIZ_RESET;
			o_read_write <= 1'b1;
			o_external_cycle_start_n <= 1'b1;
			o_operand_cycle_start_n <= 1'b1;
			o_address_strobe_n <= 1'b1;
			o_data_strobe_n <= 1'b1;
			o_data_buffer_enable_n <= 1'b1;
			o_data <= 32'h00000000;
			o_data_oe_n <= 1'b1;
		end else if (tick && state_next != state_reg) begin
			case (state_next)
				bsq_pkg::ST_S0: begin
					o_address <= ent.addr & ADDR_MASK;
					o_address_space_code <= ent.fc;
					{o_transfer_size_hi, o_transfer_size_lo} <= ent.siz;
					o_read_write <= !is_wr;
					o_external_cycle_start_n <= RED;
					o_operand_cycle_start_n <= RED
						|| !(ent.first || !is_wr);
				end
				bsq_pkg::ST_S1: begin
					o_external_cycle_start_n <= 1'b1;
					o_operand_cycle_start_n <= 1'b1;
					o_address_strobe_n <= 1'b0;
					o_data_strobe_n <= is_wr;
					o_data_buffer_enable_n <= !is_wr || RED;
				end
				bsq_pkg::ST_S2: begin
					if (is_wr) begin
						o_data <= ent.data;
						o_data_oe_n <= 1'b0;
					end else begin
						o_data_buffer_enable_n <= RED;
					end
				end
				// Write data strobe also covers any wait states
				bsq_pkg::ST_SW, bsq_pkg::ST_SWH, bsq_pkg::ST_S3: begin
					o_data_strobe_n <= 1'b0;
				end
				bsq_pkg::ST_S5: begin
					o_address_strobe_n <= 1'b1;
					o_data_strobe_n <= 1'b1;
					if (!is_wr) begin
						o_data_buffer_enable_n <= 1'b1;
					end
				end
				bsq_pkg::ST_IDLE: begin
					// Address, size and direction stay put between cycles
					o_data_buffer_enable_n <= 1'b1;
					o_data_oe_n <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is taken on the falling edge that ends S4
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rd_data <= 32'h00000000;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= 1'b0;
			if (tick && state_reg == bsq_pkg::ST_S4 && !is_wr) begin
				o_rd_data <= din_s2_reg;
				o_rd_valid <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Lock marker and bus arbitration
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_indivisible_cycle_marker_n <= 1'b1;
		end else if (start && !bad_cmd
			&& head.cyc == bsq_pkg::CYC_RMC_READ) begin
			o_indivisible_cycle_marker_n <= 1'b0;
		end else if (q.rd_ready && !bad_cmd
			&& head.cyc == bsq_pkg::CYC_RMC_END) begin
			o_indivisible_cycle_marker_n <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_bus_grant_n <= 1'b1;
		end else if (breq_s2_reg) begin
			o_bus_grant_n <= 1'b1;
		end else if (state_next == bsq_pkg::ST_IDLE && !q.rd_ready
			&& !locked) begin
			o_bus_grant_n <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	logic [6:0] ctl;
	assign ctl = {o_external_cycle_start_n, o_operand_cycle_start_n,
		o_address_strobe_n, o_data_strobe_n, o_data_buffer_enable_n,
		o_read_write, o_data_oe_n};

	write_s0_setup_a: assert property (
		(state_reg == bsq_pkg::ST_S0 && is_wr) |->
		!o_read_write && o_address == (cur_reg.addr & ADDR_MASK)
		&& o_address_space_code == cur_reg.fc)
		else $error("write S0 setup wrong");
	operand_start_a: assert property (
		(state_reg == bsq_pkg::ST_S0 && is_wr && !cur_reg.first)
		|-> o_operand_cycle_start_n)
		else $error("operand start on later write");
	write_s1_strobe_a: assert property (
		(state_reg == bsq_pkg::ST_S1 && is_wr) |->
		!o_address_strobe_n && o_data_buffer_enable_n == RED)
		else $error("write S1 strobes wrong");
	start_negated_a: assert property (
		(state_reg == bsq_pkg::ST_S1) |->
		o_external_cycle_start_n && o_operand_cycle_start_n)
		else $error("cycle start still asserted in S1");
	data_driven_a: assert property (
		(state_reg == bsq_pkg::ST_S2 && is_wr) |->
		!o_data_oe_n && o_data == cur_reg.data)
		else $error("write data not driven in S2");
	no_wait_end_a: assert property (
		(tick && state_reg == bsq_pkg::ST_S2 && ack_any) |=>
		state_reg == bsq_pkg::ST_S3 ##[1:8] state_reg == bsq_pkg::ST_S4)
		else $error("acknowledged cycle did not proceed");
	wait_insert_a: assert property (
		(tick && state_reg == bsq_pkg::ST_S2 && !ack_any) |=>
		state_reg == bsq_pkg::ST_SW)
		else $error("missing wait state");
	s4_quiet_a: assert property (
		(state_reg == bsq_pkg::ST_S4 && $past(state_reg) == bsq_pkg::ST_S3)
		|-> ctl == $past(ctl))
		else $error("control changed in S4");
	s5_release_a: assert property (
		(state_reg == bsq_pkg::ST_S5 && is_wr) |-> o_address_strobe_n
		&& o_data_strobe_n && !o_data_oe_n && !o_read_write)
		else $error("S5 write signals wrong");
	reduced_pins_a: assert property (
		RED |-> o_external_cycle_start_n && o_operand_cycle_start_n
		&& o_data_buffer_enable_n && o_address[31:24] == 8'h00)
		else $error("reduced variant drove extra pins");
	locked_marker_a: assert property (
		(state_reg != bsq_pkg::ST_IDLE && cur_reg.cyc != bsq_pkg::CYC_WRITE)
		|-> !o_indivisible_cycle_marker_n)
		else $error("marker missing in locked cycle");
	no_grant_lock_a: assert property (
		!o_indivisible_cycle_marker_n |-> o_bus_grant_n)
		else $error("bus granted during locked sequence");
	locked_read_s1_a: assert property (
		(state_reg == bsq_pkg::ST_S1 && !is_wr) |->
		!o_address_strobe_n && !o_data_strobe_n && o_data_buffer_enable_n)
		else $error("locked read S1 strobes wrong");
	locked_read_s2_a: assert property (
		(state_reg == bsq_pkg::ST_S2 && !is_wr) |->
		o_data_buffer_enable_n == RED && o_read_write)
		else $error("locked read S2 buffer enable wrong");

	write_done_c: cover property (state_reg == bsq_pkg::ST_S5 && is_wr);
	wait_seen_c: cover property (state_reg == bsq_pkg::ST_SWH);
	locked_read_c: cover property (o_rd_valid);
	grant_c: cover property (!o_bus_grant_n);

endmodule : bsq_bus_seq

/* File: bsq_slave.sv */
// Behavioural bus slave answering after a set number of clocks
`timescale 1ns/100ps
module bsq_slave (
	input  wire logic        i_sys_clk, // Clock
	input  wire logic        i_reset_n, // Reset, active low
	input  wire logic        i_as_n,    // Address strobe
	input  wire logic        i_ds_n,    // Data strobe
	input  wire logic        i_rw,      // 1 read
	input  wire logic [31:0] i_wdata,   // Data from master
	input  wire logic [3:0]  i_wait,    // Clocks before acknowledge
	input  wire logic [1:0]  i_ack_sel, // Ack lines that answer
	input  wire logic [31:0] i_rword,   // Word returned on reads
	output logic      [31:0] o_rdata,   // Data to master
	output logic             o_ack_hi_n, // Ack line 1
	output logic             o_ack_lo_n, // Ack line 0
	output logic      [31:0] o_stored   // Last word written
);
	logic [3:0] cnt;
	logic       ack;
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt <= 4'h0;
			ack <= 1'b0;
			o_stored <= 32'h0;
		end else if (i_as_n) begin
			cnt <= 4'h0;
			ack <= 1'b0;
		end else begin
			cnt <= (cnt == 4'hF) ? cnt : cnt + 4'h1;
			ack <= (cnt >= i_wait);
			if (!i_ds_n && !i_rw)
				o_stored <= i_wdata;
		end
	end
	assign o_ack_hi_n = ~(ack & i_ack_sel[1]);
	assign o_ack_lo_n = ~(ack & i_ack_sel[0]);
	// Released bus shows the inverse, never a stale copy
	assign o_rdata = (!i_as_n && i_rw) ? i_rword : ~i_rword;
endmodule : bsq_slave

/* File: tb_top.sv */
// Self-checking bench of the bus sequencer
`timescale 1ns/100ps
module tb_top;
	logic clk, rst_n, cv, first, rdy, rej, rw, ocs_n, as_n, ds_n, mk_n;
	logic ackh, ackl, req_n, gnt_n, as_q, ocs_seen, ecs_n, rdv, ecs_seen;
	logic [2:0] fc, cap_fc;
	logic [1:0] cyc, op, sel;
	logic [3:0] wt;
	logic [31:0] addr, wd, rdd, a, dout, din, rword, stored, cap_a;
	logic cap_rw;
	int errors, tests_run, ncyc, nrej, as_len, last_len, nrd;
	bsq_bus_seq #(.STATE_CYC(2)) i_bsq_bus_seq (.i_sys_clk(clk),
		.i_reset_n(rst_n), .i_cmd_valid(cv), .o_cmd_ready(rdy),
		.i_cmd_cyc(cyc), .i_cmd_op(op), .i_cmd_first(first),
		.i_cmd_fc(3'h5), .i_cmd_siz(2'h0), .i_cmd_addr(addr),
		.i_cmd_data(wd), .o_cmd_reject(rej), .o_rd_data(rdd),
		.o_rd_valid(rdv), .o_bus_clk(), .o_address(a),
		.o_address_space_code(fc), .o_transfer_size_hi(),
		.o_transfer_size_lo(), .o_read_write(rw),
		.o_external_cycle_start_n(ecs_n), .o_operand_cycle_start_n(ocs_n),
		.o_address_strobe_n(as_n), .o_data_strobe_n(ds_n),
		.o_data_buffer_enable_n(), .o_indivisible_cycle_marker_n(mk_n),
		.o_data(dout), .o_data_oe_n(), .i_data(din),
		.i_transfer_ack_hi_n(ackh), .i_transfer_ack_lo_n(ackl),
		.i_bus_request_n(req_n), .o_bus_grant_n(gnt_n));
	bsq_slave i_bsq_slave (.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_as_n(as_n), .i_ds_n(ds_n), .i_rw(rw), .i_wdata(dout),
		.i_wait(wt), .i_ack_sel(sel), .i_rword(rword), .o_rdata(din),
		.o_ack_hi_n(ackh), .o_ack_lo_n(ackl), .o_stored(stored));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Bus monitor
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		as_q <= as_n;
		as_len <= as_n ? 0 : as_len + 1;
		if (as_n && as_q === 1'b0) begin
			ncyc <= ncyc + 1;
			last_len <= as_len;
		end
		if (!as_n && as_q) begin
			cap_rw <= rw;
			cap_a <= a;
			cap_fc <= fc;
		end
		if (ocs_n === 1'b0) ocs_seen <= 1'b1;
		if (ecs_n === 1'b0) ecs_seen <= 1'b1;
		if (rej === 1'b1) nrej <= nrej + 1;
		if (rdv === 1'b1) nrd <= nrd + 1;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic send(input logic [1:0] c, o, input logic [31:0] d);
		cv <= 1'b1;
		cyc <= c;
		op <= o;
		wd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		cv <= 1'b0;
	endtask : send
	task automatic do_cmd(input logic [1:0] c, o, input logic [31:0] d);
		int n0, k;
		n0 = ncyc;
		send(c, o, d);
		for (k = 0; k < 300 && ncyc == n0; k++) @(posedge clk);
		chk("cycle end", n0 + 1, ncyc);
		@(posedge clk);
	endtask : do_cmd
	task automatic wait_gnt(input logic v);
		int k;
		for (k = 0; k < 20 && gnt_n !== v; k++) @(posedge clk);
		chk("grant", v, gnt_n);
	endtask : wait_gnt
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_write_fast();
		ocs_seen <= 1'b0;
		ecs_seen <= 1'b0;
		first <= 1'b1;
		addr <= 32'hA5C3_1F04;
		do_cmd(2'h0, 2'h0, 32'h1234_ABCD);
		chk("rw", 1'b0, cap_rw);
		chk("address", 32'hA5C3_1F04, cap_a);
		chk("stored", 32'h1234_ABCD, stored);
		chk("strobe len", 8, last_len);
		chk("op start", 1'b1, ocs_seen);
		chk("ext start", 1'b1, ecs_seen);
		chk("space", 3'h5, cap_fc);
		ocs_seen <= 1'b0;
		first <= 1'b0;
		do_cmd(2'h0, 2'h0, 32'h5A5A_0FF0);
		chk("op start", 1'b0, ocs_seen);
	endtask : sc_write_fast
	task automatic sc_write_wait();
		for (int i = 1; i < 3; i++) begin
			sel <= i[1:0];
			wt <= 4'h9;
			do_cmd(2'h0, 2'h0, 32'hC0DE_0000 + i);
			chk("waited", 1'b1, last_len > 8);
			chk("stored", 32'hC0DE_0000 + i, stored);
		end
		sel <= 2'h3;
		wt <= 4'h0;
	endtask : sc_write_wait
	task automatic sc_locked();
		int r0;
		for (int o = 1; o < 4; o++) begin
			rword <= 32'h8E00_0071 + o;
			r0 = nrd;
			do_cmd(2'h1, o[1:0], 32'h0);
			chk("rd pulse", r0 + 1, nrd);
			chk("rmc rw", 1'b1, cap_rw);
			chk("rd data", 32'h8E00_0071 + o, rdd);
			chk("marker", 1'b0, mk_n);
			req_n <= 1'b0;
			repeat (10) @(posedge clk);
			chk("no grant", 1'b1, gnt_n);
			if (o == 1) begin
				do_cmd(2'h2, 2'h1, 32'h0000_0080);
				chk("rmc store", 32'h0000_0080, stored);
				chk("marker", 1'b0, mk_n);
				// A second locked read inside the sequence is dropped
				r0 = nrej;
				send(2'h1, 2'h1, 32'h0);
				repeat (6) @(posedge clk);
				chk("reread refused", r0 + 1, nrej);
			end
			send(2'h3, o[1:0], 32'h0);
			wait_gnt(1'b0);
			chk("marker off", 1'b1, mk_n);
			req_n <= 1'b1;
			wait_gnt(1'b1);
		end
	endtask : sc_locked
	task automatic sc_refused();
		int n0, c0;
		n0 = nrej;
		c0 = ncyc;
		// Valid stays low for one edge between commands
		send(2'h2, 2'h1, 32'h0);
		@(posedge clk);
		send(2'h3, 2'h1, 32'h0);
		@(posedge clk);
		send(2'h1, 2'h0, 32'h0);
		repeat (12) @(posedge clk);
		chk("rejects", n0 + 3, nrej);
		chk("no cycles", c0, ncyc);
	endtask : sc_refused
	task automatic complete_run();
		if (errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		#200000;
		errors++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		cv = 1'b0;
		cyc = 2'h0;
		op = 2'h0;
		first = 1'b0;
		addr = 32'h0;
		wd = 32'h0;
		wt = 4'h0;
		sel = 2'h3;
		rword = 32'h0;
		req_n = 1'b1;
		errors = 0;
		tests_run = 0;
		ncyc = 0;
		nrej = 0;
		ocs_seen = 1'b0;
		ecs_seen = 1'b0;
		nrd = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		sc_write_fast();
		sc_write_wait();
		sc_locked();
		sc_refused();
		complete_run();
	end
endmodule : tb_top
